// ===== core/hps_pkg.sv
// package: register map, field positions and reset values of the slot/cap2 register group
package hps_pkg;

   // ***************************************************
   // register byte offsets
   // ***************************************************
   localparam logic [7:0] HPS_OFF_SLOT_EVENT_FLAGS = 8'hd8;
   localparam logic [7:0] HPS_OFF_DEVICE_CAPABILITY_EXT = 8'he4;
   localparam logic [7:0] HPS_OFF_DEVICE_CONTROL_EXT = 8'he8;
   localparam logic [7:0] HPS_OFF_LINK_CAPABILITY_EXT = 8'hec;
   localparam logic [7:0] HPS_OFF_LINK_CONTROL_EXT = 8'hf0;
   localparam logic [7:0] HPS_OFF_SLOT_CAPABILITY_EXT = 8'hf4;
   localparam logic [7:0] HPS_OFF_SLOT_CONTROL_EXT = 8'hf8;
   localparam int HPS_ADDR_W = 8;

   // ***************************************************
   // slot control (low half of 0xd8)
   // ***************************************************
   localparam int HPS_SC_EN_LSB = 0;
   localparam int HPS_SC_EN_W = 5;
   localparam int HPS_SC_HP_INT_EN = 5;
   localparam int HPS_SC_ATTN_LSB = 6;
   localparam int HPS_SC_PWR_IND_LSB = 8;
   localparam int HPS_SC_PWR_CTL = 10;
   localparam int HPS_SC_INTERLOCK = 11;
   localparam int HPS_SC_DLL_EN = 12;
   localparam logic [1:0] HPS_SC_ATTN_RST = 2'h3;
   localparam logic [1:0] HPS_SC_PWR_IND_RST = 2'h1;

   // ***************************************************
   // slot status (high half of 0xd8)
   // ***************************************************
   localparam int HPS_SS_BUTTON = 16;
   localparam int HPS_SS_FAULT = 17;
   localparam int HPS_SS_LATCH_CHG = 18;
   localparam int HPS_SS_PRES_CHG = 19;
   localparam int HPS_SS_CMD_DONE = 20;
   localparam int HPS_SS_LATCH_LVL = 21;
   localparam int HPS_SS_PRES_LVL = 22;
   localparam int HPS_SS_DLL_CHG = 24;

   // ***************************************************
   // capability 2 / control 2 fields
   // ***************************************************
   localparam int HPS_DC2_LTR_SUP = 11;
   localparam int HPS_DC2_FLUSH_LSB = 18;
   localparam logic [1:0] HPS_DC2_FLUSH_RST = 2'h0;
   localparam int HPS_DCT2_LTR_EN = 10;
   localparam int HPS_DCT2_FLUSH_LSB = 13;
   localparam int HPS_LC2_SPEED_LSB = 0;
   localparam logic [3:0] HPS_LC2_SPEED_RST = 4'h2;
   localparam int HPS_LC2_COMPLIANCE = 4;
   localparam int HPS_LC2_AUTOSPEED_DIS = 5;
   localparam int HPS_LC2_SEL_DEEMP = 6;
   localparam int HPS_LC2_MARGIN_LSB = 7;
   localparam int HPS_LC2_MOD_COMP = 10;
   localparam int HPS_LC2_COMP_SOS = 11;
   localparam int HPS_LC2_COMP_DEEMP = 12;
   localparam int HPS_LS2_CUR_DEEMP = 16;

   // ***************************************************
   // slot sensor indices
   // ***************************************************
   localparam int HPS_SNS_BUTTON = 0;
   localparam int HPS_SNS_FAULT = 1;
   localparam int HPS_SNS_LATCH = 2;
   localparam int HPS_SNS_PRESENCE = 3;
   localparam int HPS_SNS_COUNT = 4;

endpackage

// ===== core/hps_sense_if.sv
// interface: debounced slot sensor levels and their change events
`timescale 1ns/10ps
interface hps_sense_if #(
   parameter int N = 4
);
   logic [N-1:0] level;
   logic [N-1:0] rise;
   logic [N-1:0] change;

   modport producer (output level, output rise, output change);
   modport consumer (input level, input rise, input change);
endinterface

// ===== core/hps_sensor_sync.sv
// module: three-stage synchroniser and change detector for slot sensor pins
`timescale 1ns/10ps
module hps_sensor_sync #(
   parameter int N = 4
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // raw sensor pins
   input wire logic [N-1:0] pins_i,
   // filtered levels and events
   hps_sense_if.producer sense
);
   import hps_pkg::*;

   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] stable;
   } hps_sync_s;

   hps_sync_s state_reg;
   hps_sync_s state_next;
   logic [N-1:0] stable_new;

   // ***************************************************
   // per-bit acceptance
   // ***************************************************
   // a level is taken only once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_bit
         assign stable_new[gi] = (state_reg.s2[gi] == state_reg.s3[gi]) ? state_reg.s3[gi] : state_reg.stable[gi];
      end
   endgenerate

   // next state
   always_comb begin
      state_next = state_reg;
      state_next.s1 = pins_i;
      state_next.s2 = state_reg.s1; // s1 feeds nothing else
      state_next.s3 = state_reg.s2;
      state_next.stable = stable_new;
   end

   // state register
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // events compare each accepted level with the previous one
   assign sense.level = state_reg.stable;
   assign sense.rise = stable_new & ~state_reg.stable; // [R19]
   assign sense.change = stable_new ^ state_reg.stable; // [R19]

endmodule

// ===== core/hps_slot_cap2_regs.sv
// module: hot-plug slot status and capability 2 register group behind an APB slave
//
// Overview of operation
// R01: button press sets sticky write-one-clear bit 16
// R02: power fault sets write-one-clear bit 17
// R03: latch change sets read-only bit 18
// R04: presence change sets write-one-clear bit 19
// R05: finished controller command sets bit 19+1
// R06: bit 21 shows latch level, one open
// R07: bit 22 shows card presence, reset zero
// R08: no slot implemented: presence bit reads one
// R09: link-active change sets write-one-clear bit 24
// R10: capability 2 bit 11 reads one
// R11: buffer-flush support bits 19:18, loadable default
// R12: control 2 bits 10, 14:13 writable
// R13: select de-emphasis bit 6, port-dependent reset
// R14: current de-emphasis bit 16, port-dependent reset
// R15: interrupt needs global bit 5 and event enable
// R16: link-active notify needs slot control bit 12
// R17: writing one clears, zero leaves unchanged
// R18: reserved and unimplemented bits read zero
// R19: sensor change is sampled level versus previous
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module hps_slot_cap2_regs #(
   parameter bit IS_DOWNSTREAM = 1'b1,
   parameter bit SLOT_IMPLEMENTED = 1'b1
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [hps_pkg::HPS_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // slot sensor pins
   input wire logic attn_button_i,
   input wire logic power_fault_i,
   input wire logic retention_latch_open_i,
   input wire logic card_present_i,
   // hot-plug controller and link layer
   input wire logic cmd_done_i,
   input wire logic link_active_i,
   input wire logic link_deemph_i,
   // configuration load
   input wire logic cfg_load_i,
   input wire logic [1:0] cfg_flush_sup_i,
   input wire logic cfg_sel_deemp_i,
   // interrupt and control outputs
   output logic hp_irq_o,
   output logic ltr_en_o,
   output logic [1:0] flush_en_o
);
   import hps_pkg::*;

   // ***************************************************
   // state
   // ***************************************************
   // every register of the group in one packed word, so the
   // reset image and the next-state copy cannot drift apart
   typedef struct packed {
      logic [HPS_SC_EN_W-1:0] ev_en;
      logic hp_int_en;
      logic [1:0] attn_ind;
      logic [1:0] pwr_ind;
      logic pwr_ctl;
      logic interlock;
      logic dll_en;
      // sticky event flags, upper half of the flag word
      logic st_button;
      logic st_fault;
      logic st_latch_chg;
      logic st_pres_chg;
      logic st_cmd_done;
      logic st_dll_chg;
      // last link-active level for change detection
      logic link_prev;
      // capability 2 and control 2 fields
      logic ltr_en;
      logic [1:0] flush_en;
      logic [1:0] flush_sup;
      logic [3:0] tgt_speed;
      logic enter_comp;
      logic autospeed_dis;
      logic sel_deemp;
      logic [2:0] margin;
      logic mod_comp;
      logic comp_sos;
      logic comp_deemp;
      logic cur_deemp;
      // bus answer and interrupt, registered
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic irq;
   } hps_regs_s;

   // reset image; de-emphasis bits depend on the port direction
   localparam hps_regs_s HPS_RESET = '{
      ev_en: '0,
      hp_int_en: 1'b0,
      attn_ind: HPS_SC_ATTN_RST,
      pwr_ind: HPS_SC_PWR_IND_RST,
      pwr_ctl: 1'b0,
      interlock: 1'b0,
      dll_en: 1'b0,
      st_button: 1'b0,
      st_fault: 1'b0,
      st_latch_chg: 1'b0,
      st_pres_chg: 1'b0,
      st_cmd_done: 1'b0,
      st_dll_chg: 1'b0,
      link_prev: 1'b0,
      ltr_en: 1'b0,
      flush_en: 2'h0,
      flush_sup: HPS_DC2_FLUSH_RST,
      tgt_speed: HPS_LC2_SPEED_RST,
      enter_comp: 1'b0,
      autospeed_dis: 1'b0,
      sel_deemp: IS_DOWNSTREAM,
      margin: 3'h0,
      mod_comp: 1'b0,
      comp_sos: 1'b0,
      comp_deemp: 1'b0,
      cur_deemp: IS_DOWNSTREAM,
      rdata: 32'h0,
      ready: 1'b0,
      slverr: 1'b0,
      irq: 1'b0
   }; // [R13] [R14] [R11]

   hps_regs_s state_reg;
   hps_regs_s state_next;

   // ***************************************************
   // sensor synchronisers
   // ***************************************************
   // the sensor pins are asynchronous; no flag sees them before
   // the synchroniser has accepted a level
   hps_sense_if #(.N(HPS_SNS_COUNT)) sense ();
   logic [HPS_SNS_COUNT-1:0] sensor_pins;

   assign sensor_pins[HPS_SNS_BUTTON] = attn_button_i;
   assign sensor_pins[HPS_SNS_FAULT] = power_fault_i;
   assign sensor_pins[HPS_SNS_LATCH] = retention_latch_open_i;
   assign sensor_pins[HPS_SNS_PRESENCE] = card_present_i;

   hps_sensor_sync #(
      .N(HPS_SNS_COUNT)
   ) u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .pins_i(sensor_pins),
      .sense(sense.producer)
   );

   // ***************************************************
   // decode helpers
   // ***************************************************
   // one word per offset; anything else answers with an error
   // control and status halves of 0xe8, 0xf0, 0xf8 share a word
   function automatic logic is_mapped(input logic [HPS_ADDR_W-1:0] a);
      case (a)
         HPS_OFF_SLOT_EVENT_FLAGS,
         HPS_OFF_DEVICE_CAPABILITY_EXT,
         HPS_OFF_DEVICE_CONTROL_EXT,
         HPS_OFF_LINK_CAPABILITY_EXT,
         HPS_OFF_LINK_CONTROL_EXT,
         HPS_OFF_SLOT_CAPABILITY_EXT,
         HPS_OFF_SLOT_CONTROL_EXT: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   // read image of one register word
   function automatic logic [31:0] read_word(input logic [HPS_ADDR_W-1:0] a, input hps_regs_s s,
                                             input logic latch_lvl, input logic pres_lvl);
      logic [31:0] w;
      w = 32'h0; // [R18]
      case (a)
         HPS_OFF_SLOT_EVENT_FLAGS: begin
            w[HPS_SC_EN_LSB +: HPS_SC_EN_W] = s.ev_en;
            w[HPS_SC_HP_INT_EN] = s.hp_int_en;
            w[HPS_SC_ATTN_LSB +: 2] = s.attn_ind;
            w[HPS_SC_PWR_IND_LSB +: 2] = s.pwr_ind;
            w[HPS_SC_PWR_CTL] = s.pwr_ctl;
            w[HPS_SC_INTERLOCK] = s.interlock;
            w[HPS_SC_DLL_EN] = s.dll_en;
            w[HPS_SS_BUTTON] = s.st_button;
            w[HPS_SS_FAULT] = s.st_fault;
            w[HPS_SS_LATCH_CHG] = s.st_latch_chg;
            w[HPS_SS_PRES_CHG] = s.st_pres_chg;
            w[HPS_SS_CMD_DONE] = s.st_cmd_done;
            // levels are live, not latched: they follow the sensors
            w[HPS_SS_LATCH_LVL] = latch_lvl; // [R06]
            w[HPS_SS_PRES_LVL] = SLOT_IMPLEMENTED ? pres_lvl : 1'b1; // [R07] [R08]
            w[HPS_SS_DLL_CHG] = s.st_dll_chg;
         end
         HPS_OFF_DEVICE_CAPABILITY_EXT: begin
            w[HPS_DC2_LTR_SUP] = 1'b1; // [R10]
            w[HPS_DC2_FLUSH_LSB +: 2] = s.flush_sup; // [R11]
         end
         HPS_OFF_DEVICE_CONTROL_EXT: begin
            w[HPS_DCT2_LTR_EN] = s.ltr_en; // [R12]
            w[HPS_DCT2_FLUSH_LSB +: 2] = s.flush_en; // [R12]
         end
         HPS_OFF_LINK_CONTROL_EXT: begin
            w[HPS_LC2_SPEED_LSB +: 4] = s.tgt_speed;
            w[HPS_LC2_COMPLIANCE] = s.enter_comp;
            w[HPS_LC2_AUTOSPEED_DIS] = s.autospeed_dis;
            w[HPS_LC2_SEL_DEEMP] = s.sel_deemp; // [R13]
            w[HPS_LC2_MARGIN_LSB +: 3] = s.margin;
            w[HPS_LC2_MOD_COMP] = s.mod_comp;
            w[HPS_LC2_COMP_SOS] = s.comp_sos;
            w[HPS_LC2_COMP_DEEMP] = s.comp_deemp;
            w[HPS_LS2_CUR_DEEMP] = s.cur_deemp; // [R14]
         end
         // link cap 2, slot cap 2 and slot ctl/sts 2 read zero
         default: w = 32'h0; // [R18]
      endcase
      read_word = w;
   endfunction

   // ***************************************************
   // bus strobes
   // ***************************************************
   logic setup_phase;
   logic wr_hit;
   logic [31:0] wmask;
   logic [31:0] wmerge;
   logic [31:0] cur_word;
   logic [31:0] clr;

   // the read image is latched in setup so that prdata comes from a flop;
   // this adds no wait state: pready is high in the first access cycle
   assign setup_phase = psel_i & ~penable_i;
   assign wr_hit = psel_i & penable_i & state_reg.ready & pwrite_i & ~state_reg.slverr;
   assign wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
   assign cur_word = read_word(paddr_i, state_reg, sense.level[HPS_SNS_LATCH], sense.level[HPS_SNS_PRESENCE]);
   assign wmerge = (cur_word & ~wmask) | (pwdata_i & wmask);
   // clears act only on the strobed lanes of the flag word
   assign clr = (wr_hit && paddr_i == HPS_OFF_SLOT_EVENT_FLAGS) ? (pwdata_i & wmask) : 32'h0; // [R17]

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      state_next = state_reg;

      // apb answer: ready and data for exactly one access cycle
      state_next.ready = setup_phase;
      state_next.slverr = setup_phase & ~is_mapped(paddr_i);
      state_next.rdata = setup_phase ? cur_word : 32'h0;

      // writable fields
      if (wr_hit) begin
         case (paddr_i)
            HPS_OFF_SLOT_EVENT_FLAGS: begin
               state_next.ev_en = wmerge[HPS_SC_EN_LSB +: HPS_SC_EN_W];
               state_next.hp_int_en = wmerge[HPS_SC_HP_INT_EN];
               state_next.attn_ind = wmerge[HPS_SC_ATTN_LSB +: 2];
               state_next.pwr_ind = wmerge[HPS_SC_PWR_IND_LSB +: 2];
               state_next.pwr_ctl = wmerge[HPS_SC_PWR_CTL];
               state_next.interlock = wmerge[HPS_SC_INTERLOCK];
               state_next.dll_en = wmerge[HPS_SC_DLL_EN];
            end
            HPS_OFF_DEVICE_CONTROL_EXT: begin
               state_next.ltr_en = wmerge[HPS_DCT2_LTR_EN]; // [R12]
               state_next.flush_en = wmerge[HPS_DCT2_FLUSH_LSB +: 2]; // [R12]
            end
            HPS_OFF_LINK_CONTROL_EXT: begin
               state_next.tgt_speed = wmerge[HPS_LC2_SPEED_LSB +: 4];
               state_next.enter_comp = wmerge[HPS_LC2_COMPLIANCE];
               state_next.autospeed_dis = wmerge[HPS_LC2_AUTOSPEED_DIS];
               state_next.margin = wmerge[HPS_LC2_MARGIN_LSB +: 3];
               state_next.mod_comp = wmerge[HPS_LC2_MOD_COMP];
               state_next.comp_sos = wmerge[HPS_LC2_COMP_SOS];
               state_next.comp_deemp = wmerge[HPS_LC2_COMP_DEEMP];
            end
            default: begin
               state_next.ltr_en = state_reg.ltr_en; // read-only words ignore writes [R18]
            end
         endcase
      end

      // sticky slot events: a set in the clearing cycle wins
      state_next.st_button = (state_reg.st_button & ~clr[HPS_SS_BUTTON])
                             | sense.rise[HPS_SNS_BUTTON]; // [R01] [R17]
      state_next.st_fault = (state_reg.st_fault & ~clr[HPS_SS_FAULT])
                            | sense.rise[HPS_SNS_FAULT]; // [R02] [R17]
      // read-only change flag: no software clear, only reset
      state_next.st_latch_chg = state_reg.st_latch_chg | sense.change[HPS_SNS_LATCH]; // [R03]
      state_next.st_pres_chg = (state_reg.st_pres_chg & ~clr[HPS_SS_PRES_CHG])
                               | sense.change[HPS_SNS_PRESENCE]; // [R04] [R17]
      state_next.st_cmd_done = (state_reg.st_cmd_done & ~clr[HPS_SS_CMD_DONE]) | cmd_done_i; // [R05] [R17]
      // link-active is on our clock: no synchroniser, one compare
      state_next.link_prev = link_active_i;
      state_next.st_dll_chg = (state_reg.st_dll_chg & ~clr[HPS_SS_DLL_CHG])
                              | (link_active_i ^ state_reg.link_prev); // [R09] [R17]

      // external configuration load replaces the loadable defaults
      if (cfg_load_i) begin
         state_next.flush_sup = cfg_flush_sup_i; // [R11]
         state_next.sel_deemp = IS_DOWNSTREAM ? cfg_sel_deemp_i : 1'b0; // [R13]
      end
      // current level leaves its reset value at the first edge
      state_next.cur_deemp = link_deemph_i; // [R14]

      // the line lags its flag by one edge but comes from a flop
      // one level interrupt from enabled sticky events
      state_next.irq = state_reg.hp_int_en & ( // [R15]
                          (state_reg.st_button & state_reg.ev_en[HPS_SNS_BUTTON])
                        | (state_reg.st_fault & state_reg.ev_en[HPS_SNS_FAULT])
                        | (state_reg.st_latch_chg & state_reg.ev_en[HPS_SNS_LATCH])
                        | (state_reg.st_pres_chg & state_reg.ev_en[HPS_SNS_PRESENCE])
                        | (state_reg.st_cmd_done & state_reg.ev_en[HPS_SC_EN_W-1])
                        | (state_reg.st_dll_chg & state_reg.dll_en)); // [R16]
   end

   // ***************************************************
   // state register
   // ***************************************************
   // asynchronous reset loads a constant image only
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= HPS_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // limitation: the line drops one edge after its last flag clears
   // outputs straight from flops
   assign prdata_o = state_reg.rdata;
   assign pready_o = state_reg.ready;
   assign pslverr_o = state_reg.slverr;
   assign hp_irq_o = state_reg.irq;
   assign ltr_en_o = state_reg.ltr_en;
   assign flush_en_o = state_reg.flush_en;

endmodule

// ===== bench/hps_slot_model.sv
// slot sensor model: attention button, power fault, retention latch, card presence
`timescale 1ns/10ps
module hps_slot_model (
   // clock
   input wire logic mclk_i,
   // sensor pins
   output logic attn_button_o,
   output logic power_fault_o,
   output logic latch_open_o,
   output logic card_present_o
);
   // pins idle: released button, no fault, latch closed, slot empty
   initial begin
      attn_button_o = 1'b0;
      power_fault_o = 1'b0;
      latch_open_o = 1'b0;
      card_present_o = 1'b0;
   end
   // a button press lasts long enough to pass the synchroniser
   task automatic press();
      attn_button_o <= 1'b1;
      repeat (6) @(posedge mclk_i);
      attn_button_o <= 1'b0;
   endtask
   // levels change just after an edge, like a real sensor held steady
   task automatic set_pins(input logic f, input logic l, input logic p);
      power_fault_o <= f;
      latch_open_o <= l;
      card_present_o <= p;
   endtask
endmodule

// ===== bench/hps_slot_cap2_regs_chk.sv
// checker: bus answer and interrupt relations of the slot register group
`timescale 1ns/10ps
module hps_slot_cap2_regs_chk (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [hps_pkg::HPS_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // outputs and event inputs
   input wire logic cmd_done_i,
   input wire logic link_active_i,
   input wire logic hp_irq_o,
   input wire logic ltr_en_o,
   input wire logic [1:0] flush_en_o
);
   import hps_pkg::*;
   logic [2:0] ctl_q;
   logic [2:0] dc_q;
   logic wr;
   assign wr = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
   // shadow of enables software wrote; bench always strobes all lanes
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_q <= 3'h0;
         dc_q <= 3'h0;
      end else begin
         if (wr && paddr_i == HPS_OFF_SLOT_EVENT_FLAGS) ctl_q <= {pwdata_i[12], pwdata_i[5], pwdata_i[4]};
         if (wr && paddr_i == HPS_OFF_DEVICE_CONTROL_EXT) dc_q <= {pwdata_i[14:13], pwdata_i[10]};
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence setup_s;
      psel_i && !penable_i;
   endsequence
   sequence done_s;
      cmd_done_i && ctl_q[1] && ctl_q[0];
   endsequence
   sequence link_s;
      $changed(link_active_i) && ctl_q[2] && ctl_q[1];
   endsequence
   pready_one_a: assert property (setup_s |=> pready_o) else $error("no answer after setup");
   pready_pulse_a: assert property (pready_o |=> !pready_o) else $error("answer held too long");
   rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o) else $error("idle bus not zero");
   slverr_map_a: assert property (pslverr_o |-> prdata_o == 32'h0 && !(paddr_i inside {8'hd8, 8'he4, 8'he8,
      8'hec, 8'hf0, 8'hf4, 8'hf8})) else $error("error on mapped place");
   irq_gate_a: assert property (hp_irq_o |-> ctl_q[1] || $past(ctl_q[1])) else $error("irq without enable");
   cmd_irq_a: assert property (done_s |-> ##[1:3] hp_irq_o) else $error("command irq missing");
   link_irq_a: assert property (link_s |-> ##[1:4] hp_irq_o) else $error("link irq missing");
   ctl_copy_a: assert property ($changed(dc_q) |-> ##[0:1] (ltr_en_o == dc_q[0] && flush_en_o == dc_q[2:1]))
      else $error("control copy stale");
endmodule
bind hps_slot_cap2_regs hps_slot_cap2_regs_chk i_chk (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cmd_done_i, .link_active_i, .hp_irq_o,
   .ltr_en_o, .flush_en_o);

// ===== bench/hps_slot_cap2_regs_tb_top.sv
// testbench: apb reads and writes, slot events and interrupt of the register group
`timescale 1ns/10ps
module hps_slot_cap2_regs_tb_top;
   logic mclk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, prdata_u, d;
   logic [3:0] pstrb_i = 4'hf;
   logic pready_o, pslverr_o, hp_irq_o, ltr_en_o, cmd_done_i = 1'b0, link_active_i = 1'b0;
   logic link_deemph_i = 1'b1, cfg_load_i = 1'b0, cfg_sel_deemp_i = 1'b1;
   logic attn_button_i, power_fault_i, retention_latch_open_i, card_present_i;
   logic [1:0] flush_en_o, cfg_flush_sup_i = 2'h0;
   logic [32:0] eq [$];
   logic [32:0] e;
   logic [7:0] ra [8] = '{8'hd8, 8'he4, 8'he8, 8'hec, 8'hf0, 8'hf4, 8'hf8, 8'hdc};
   logic [32:0] rv [8] = '{33'h1c0, 33'h800, 33'h0, 33'h0, 33'h10042, 33'h0, 33'h0, 33'h100000000};
   int num_errors = 0, cmp_count = 0, cyc = 0, seed = 32'hf183e43c;
   always #4 mclk_i = ~mclk_i;
   hps_slot_cap2_regs i_hps_slot_cap2_regs (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .attn_button_i, .power_fault_i,
      .retention_latch_open_i, .card_present_i, .cmd_done_i, .link_active_i, .link_deemph_i, .cfg_load_i,
      .cfg_flush_sup_i, .cfg_sel_deemp_i, .hp_irq_o, .ltr_en_o, .flush_en_o);
   // upstream port without a slot: forced presence, no de-emphasis select
   hps_slot_cap2_regs #(.IS_DOWNSTREAM(1'b0), .SLOT_IMPLEMENTED(1'b0)) i_hps_slot_cap2_regs_up (.mclk_i,
      .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o(prdata_u),
      .pready_o(), .pslverr_o(), .attn_button_i, .power_fault_i, .retention_latch_open_i, .card_present_i,
      .cmd_done_i, .link_active_i, .link_deemph_i, .cfg_load_i, .cfg_flush_sup_i, .cfg_sel_deemp_i,
      .hp_irq_o(), .ltr_en_o(), .flush_en_o());
   hps_slot_model i_hps_slot_model (.mclk_i, .attn_button_o(attn_button_i), .power_fault_o(power_fault_i),
      .latch_open_o(retention_latch_open_i), .card_present_o(card_present_i));
   // ***************************************************
   // compare, report and bus tasks
   // ***************************************************
   task automatic chk(input string n, input logic [32:0] x, input logic [32:0] g);
      cmp_count++;
      if (g !== x) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic summarize();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // setup then access; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [32:0] x);
      int n;
      n = 0;
      if (!w) eq.push_back(x);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= v;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) num_errors++; // no answer counts as a mismatch
   endtask
   task automatic idle(input int n);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      repeat (n) @(posedge mclk_i);
   endtask
   // monitor: each read answer is matched with the oldest note
   always @(posedge mclk_i) begin
      if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
         if (eq.size() == 0) chk("unexpected read", 33'h0, 33'h1);
         else begin
            e = eq.pop_front();
            chk("read data", e, {pslverr_o, prdata_o});
            if (paddr_i == 8'hd8) chk("presence forced", 33'h1, {32'h0, prdata_u[22]});
            if (paddr_i == 8'hf0) chk("upstream deemp", 33'h0, {32'h0, prdata_u[6]});
         end
      end
   end
   // hang guard: a run needs well under a thousand cycles
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc > 5000) begin
         num_errors++;
         summarize();
      end
   end
   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_i <= 1'b0;
      apb(1, 8'hdc, 32'hffffffff, 33'h0);
      for (int i = 0; i < 8; i++) apb(0, ra[i], 32'h0, rv[i]);
      d = $random(seed);
      apb(1, 8'he8, d, 33'h0);
      apb(0, 8'he8, 32'h0, {1'b0, d & 32'h6400});
      apb(1, 8'hf0, 32'hffffffff, 33'h0);
      apb(1, 8'he4, 32'hffffffff, 33'h0);
      apb(0, 8'hf0, 32'h0, 33'h11fff);
      apb(0, 8'he4, 32'h0, 33'h800);
      idle(2);
      chk("ltr enable", {32'h0, ltr_en_o}, {32'h0, d[10]});
      chk("flush enable", {31'h0, flush_en_o}, {31'h0, d[14:13]});
      cfg_flush_sup_i <= 2'h3;
      cfg_sel_deemp_i <= 1'b0;
      cfg_load_i <= 1'b1;
      @(posedge mclk_i);
      cfg_load_i <= 1'b0;
      link_deemph_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      apb(0, 8'he4, 32'h0, 33'hc0800);
      apb(0, 8'hf0, 32'h0, 33'h1fbf);
      apb(1, 8'hd8, 32'h12ff, 33'h0);
      idle(1);
      i_hps_slot_model.set_pins(1'b1, 1'b1, 1'b1);
      cmd_done_i <= 1'b1;
      link_active_i <= 1'b1;
      @(posedge mclk_i);
      cmd_done_i <= 1'b0;
      i_hps_slot_model.press();
      repeat (8) @(posedge mclk_i);
      chk("irq raised", 33'h1, {32'h0, hp_irq_o});
      apb(0, 8'hd8, 32'h0, 33'h17f12ff);
      apb(1, 8'hd8, 32'h12ff, 33'h0);
      apb(0, 8'hd8, 32'h0, 33'h17f12ff);
      apb(1, 8'hd8, 32'h01ff12ff, 33'h0);
      apb(0, 8'hd8, 32'h0, 33'h6412ff);
      idle(3);
      chk("irq latch", 33'h1, {32'h0, hp_irq_o});
      apb(1, 8'hd8, 32'h12df, 33'h0);
      idle(3);
      chk("irq masked", 33'h0, {32'h0, hp_irq_o});
      apb(1, 8'hd8, 32'h02fb, 33'h0);
      idle(1);
      link_active_i <= 1'b0;
      repeat (8) @(posedge mclk_i);
      chk("irq link off", 33'h0, {32'h0, hp_irq_o});
      apb(0, 8'hd8, 32'h0, 33'h16402fb);
      idle(3);
      chk("queue empty", 33'h0, {1'b0, 32'(eq.size())});
      summarize();
   end
endmodule
